// [logic/timer8_compare_normal_ctc.sv]
// 8-bit timer with two compare channels, normal and clear-on-match modes
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_normal_ctc
    import timer8_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // prescaled timer clock enable
    input wire logic timer_tick,
    // interrupt service acknowledge per flag
    input wire timer8_pkg::flag_set_type flag_service,
    // axi4-lite write address
    input wire logic [timer8_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [timer8_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // waveform pins
    output timer8_pkg::wave_pin_type wave_pin_a,
    output timer8_pkg::wave_pin_type wave_pin_b
);
    import timer8_pkg::*;

    chan_state_type wstate;
    chan_state_type rstate;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] ar_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic count_wr;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [2:0] waveform_mode_select;
    logic [2:0] clock_source_select;
    logic [1:0] output_action_select [NUM_CH];
    logic [7:0] compare_value_n [NUM_CH];
    logic [1:0] wave_pin_direction_bit;
    logic [1:0] port_value;
    logic [7:0] count_value;
    logic block_pending;
    logic overflow_flag;
    logic match_flag_n [NUM_CH];
    logic wave_output_n [NUM_CH];
    logic match_ev [NUM_CH];
    logic force_fire [NUM_CH];
    wave_pin_type pin_q [NUM_CH];
    logic tick;
    logic non_pwm;
    logic [NUM_CH-1:0] service_match;

    assign wr_fire = (wstate == chan_busy);
    assign count_wr = wr_fire && (aw_addr == OFS_COUNT) && w_strb[0];
    // ------------------------------------------------------------
    // timer tick gating
    // ------------------------------------------------------------
    // stopped select
    assign tick = timer_tick && (clock_source_select != CS_STOPPED);
    assign non_pwm = (waveform_mode_select == MODE_NORMAL)
        || (waveform_mode_select == MODE_CLEAR_ON_MATCH);
    assign service_match = {flag_service.match_b, flag_service.match_a};
    assign wave_pin_a = pin_q[0];
    assign wave_pin_b = pin_q[1];

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate <= chan_idle;
            awready <= 1'b0;
            wready <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (clk_en) begin
            case (wstate)
                chan_idle: begin
                    awready <= !aw_got && !(awvalid && awready);
                    wready <= !w_got && !(wvalid && wready);
                    if (awvalid && awready) begin
                        aw_addr <= awaddr;
                        aw_got <= 1'b1;
                    end
                    if (wvalid && wready) begin
                        w_data <= wdata;
                        w_strb <= wstrb;
                        w_got <= 1'b1;
                    end
                    if (aw_got && w_got) begin
                        awready <= 1'b0;
                        wready <= 1'b0;
                        wstate <= chan_busy;
                    end
                end
                chan_busy: begin
                    aw_got <= 1'b0;
                    w_got <= 1'b0;
                    bvalid <= 1'b1;
                    if (aw_addr[1:0] != 2'b00 || aw_addr > OFS_STATUS) begin
                        bresp <= RESP_SLVERR;
                    end else begin
                        bresp <= RESP_OKAY;
                    end
                    wstate <= chan_resp;
                end
                chan_resp: begin
                    if (bready) begin
                        bvalid <= 1'b0;
                        wstate <= chan_idle;
                    end
                end
                default: begin
                    wstate <= chan_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        if (ar_addr == OFS_CTRL) begin
            next_rdata[CTRL_MODE_LSB +: 3] = waveform_mode_select;
            next_rdata[CTRL_ACT_A_LSB +: 2] = output_action_select[0];
            next_rdata[CTRL_ACT_B_LSB +: 2] = output_action_select[1];
            next_rdata[CTRL_CS_LSB +: 3] = clock_source_select;
        end else if (ar_addr == OFS_COUNT) begin
            next_rdata[7:0] = count_value;
        end else if (ar_addr == OFS_COMPARE_A) begin
            next_rdata[7:0] = compare_value_n[0];
        end else if (ar_addr == OFS_COMPARE_B) begin
            next_rdata[7:0] = compare_value_n[1];
        end else if (ar_addr == OFS_FLAGS) begin
            next_rdata[FLAG_OVF_BIT] = overflow_flag;
            next_rdata[FLAG_MATCH_A_BIT] = match_flag_n[0];
            next_rdata[FLAG_MATCH_A_BIT + 1] = match_flag_n[1];
        end else if (ar_addr == OFS_FORCE) begin
            next_rdata = '0;
        end else if (ar_addr == OFS_PIN) begin
            next_rdata[PIN_DIR_LSB +: 2] = wave_pin_direction_bit;
            next_rdata[PIN_PORT_LSB +: 2] = port_value;
        end else if (ar_addr == OFS_STATUS) begin
            next_rdata[0] = wave_output_n[0];
            next_rdata[1] = wave_output_n[1];
        end else begin
            next_rresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rstate <= chan_idle;
            arready <= 1'b0;
            ar_addr <= '0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (clk_en) begin
            case (rstate)
                chan_idle: begin
                    arready <= !(arvalid && arready);
                    if (arvalid && arready) begin
                        ar_addr <= araddr;
                        rstate <= chan_busy;
                    end
                end
                chan_busy: begin
                    rdata <= next_rdata;
                    rresp <= next_rresp;
                    rvalid <= 1'b1;
                    rstate <= chan_resp;
                end
                chan_resp: begin
                    if (rready) begin
                        rvalid <= 1'b0;
                        rstate <= chan_idle;
                    end
                end
                default: begin
                    rstate <= chan_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control and compare registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waveform_mode_select <= MODE_RESET;
            clock_source_select <= CS_STOPPED;
            output_action_select[0] <= ACT_NONE;
            output_action_select[1] <= ACT_NONE;
            compare_value_n[0] <= COMPARE_RESET;
            compare_value_n[1] <= COMPARE_RESET;
            wave_pin_direction_bit <= '0;
            port_value <= '0;
        end else if (clk_en && wr_fire) begin
            if (aw_addr == OFS_CTRL && w_strb[0]) begin
                waveform_mode_select <= w_data[CTRL_MODE_LSB +: 3];
                output_action_select[0] <= w_data[CTRL_ACT_A_LSB +: 2];
                output_action_select[1] <= w_data[CTRL_ACT_B_LSB +: 2];
            end
            if (aw_addr == OFS_CTRL && w_strb[1]) begin
                clock_source_select <= w_data[CTRL_CS_LSB +: 3];
            end
            if (aw_addr == OFS_COMPARE_A && w_strb[0]) begin
                compare_value_n[0] <= w_data[7:0];
            end
            if (aw_addr == OFS_COMPARE_B && w_strb[0]) begin
                compare_value_n[1] <= w_data[7:0];
            end
            if (aw_addr == OFS_PIN && w_strb[0]) begin
                wave_pin_direction_bit <= w_data[PIN_DIR_LSB +: 2];
                port_value <= w_data[PIN_PORT_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // counter and overflow flag
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value <= COUNT_RESET;
            block_pending <= 1'b0;
        end else if (clk_en) begin
            if (count_wr) begin
                count_value <= w_data[7:0];
            end else if (tick && non_pwm) begin
                if (waveform_mode_select == MODE_CLEAR_ON_MATCH
                        && count_value == compare_value_n[0]) begin
                    count_value <= COUNT_BOTTOM;
                end else begin
                    count_value <= 8'(count_value + 8'h01);
                end
            end
            if (count_wr) begin
                block_pending <= 1'b1;
            end else if (tick) begin
                block_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
        end else if (clk_en) begin
            if (flag_service.overflow || (wr_fire && aw_addr == OFS_FLAGS
                    && w_strb[0] && w_data[FLAG_OVF_BIT])) begin
                overflow_flag <= 1'b0;
            end
            if (tick && non_pwm && !count_wr && count_value == COUNT_MAX) begin
                overflow_flag <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign match_ev[i] = tick && !block_pending
            && (count_value == compare_value_n[i]);
        assign force_fire[i] = wr_fire && (aw_addr == OFS_FORCE) && w_strb[0]
            && w_data[i] && non_pwm;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                match_flag_n[i] <= 1'b0;
            end else if (clk_en) begin
                if (service_match[i] || (wr_fire && aw_addr == OFS_FLAGS
                        && w_strb[0] && w_data[FLAG_MATCH_A_BIT + i])) begin
                    match_flag_n[i] <= 1'b0;
                end
                if (match_ev[i]) begin
                    match_flag_n[i] <= 1'b1;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                wave_output_n[i] <= 1'b0;
            end else if (clk_en && non_pwm && (match_ev[i] || force_fire[i])) begin
                case (output_action_select[i])
                    ACT_TOGGLE: wave_output_n[i] <= !wave_output_n[i];
                    ACT_CLEAR: wave_output_n[i] <= 1'b0;
                    ACT_SET: wave_output_n[i] <= 1'b1;
                    default: wave_output_n[i] <= wave_output_n[i];
                endcase
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_q[i] <= '{level: 1'b0, drive_n: 1'b1};
            end else if (clk_en) begin
                pin_q[i].level <= (output_action_select[i] != ACT_NONE)
                    ? wave_output_n[i] : port_value[i];
                pin_q[i].drive_n <= !wave_pin_direction_bit[i];
            end
        end

        force_no_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
            clk_en && force_fire[i] && !match_ev[i] && !match_flag_n[i]
            |=> !match_flag_n[i])
            else $error("force strobe set a match flag");
        force_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
            clk_en && force_fire[i] && output_action_select[i] == ACT_SET
            |=> wave_output_n[i])
            else $error("forced set did not set output");
        state_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
            !(clk_en && non_pwm && (match_ev[i] || force_fire[i]))
            |=> $stable(wave_output_n[i]))
            else $error("output state changed without event");
        pin_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
            clk_en && output_action_select[i] != ACT_NONE
            |=> pin_q[i].level == $past(wave_output_n[i]))
            else $error("pin does not follow wave state");
        pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
            clk_en ##1 1'b1 |-> pin_q[i].drive_n == !$past(wave_pin_direction_bit[i]))
            else $error("pin drive does not follow direction");
        reset_state_a: assert property (@(posedge aclk)
            !aresetn |=> !wave_output_n[i] && !match_flag_n[i])
            else $error("reset left output state set");
    end

    // ------------------------------------------------------------
    // counter checks
    // ------------------------------------------------------------
    count_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && count_wr |=> !match_ev[0] && !match_ev[1])
        else $error("match not blocked after count write");
    count_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && count_wr |=> count_value == $past(w_data[7:0]))
        else $error("count write lost");
    normal_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && tick && !count_wr && waveform_mode_select == MODE_NORMAL
        && count_value == COUNT_MAX |=> count_value == COUNT_BOTTOM && overflow_flag)
        else $error("normal wrap or overflow wrong");
    top_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && tick && !count_wr && waveform_mode_select == MODE_CLEAR_ON_MATCH
        && count_value == compare_value_n[0] |=> count_value == COUNT_BOTTOM)
        else $error("count not cleared at compare a");
    stopped_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && clock_source_select == CS_STOPPED && !count_wr |=> $stable(count_value))
        else $error("counter advanced while stopped");
endmodule // timer8_compare_normal_ctc
`default_nettype wire

// [logic/timer8_pkg.sv]
// constants and types for the 8-bit timer compare block
`default_nettype none
package timer8_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COMPARE_A = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COMPARE_B = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PIN = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACT_A_LSB = 4;
    localparam int CTRL_ACT_B_LSB = 6;
    localparam int CTRL_CS_LSB = 8;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_MATCH_A_BIT = 1;
    localparam int PIN_DIR_LSB = 0;
    localparam int PIN_PORT_LSB = 2;
    // ------------------------------------------------------------
    // values and reset values
    // ------------------------------------------------------------
    localparam int NUM_CH = 2;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] CS_STOPPED = 3'h0;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        chan_idle = 2'b00,
        chan_busy = 2'b01,
        chan_resp = 2'b11
    } chan_state_type;
    typedef struct packed {
        logic level;
        logic drive_n;
    } wave_pin_type;
    typedef struct packed {
        logic overflow;
        logic match_a;
        logic match_b;
    } flag_set_type;
endpackage
`default_nettype wire

// [dv/pin_model.sv]
// port pin with a weak pull-down, as seen by the outside world
`timescale 1ns/1ps
`default_nettype none
module pin_model
    import timer8_pkg::*;
(
    // pin driver from the block
    input wire timer8_pkg::wave_pin_type pin,
    // resolved pin line
    output logic line
);
    assign line = pin.drive_n ? 1'b0 : pin.level;
endmodule // pin_model
`default_nettype wire

// [dv/test_timer8_compare_normal_ctc.sv]
// self-checking bench for the 8-bit timer compare block
`timescale 1ns/1ps
`default_nettype none
module test_timer8_compare_normal_ctc;
    import timer8_pkg::*;
    logic aclk = 0, aresetn = 0, tick = 1, line_a, line_b;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rs, st, bs;
    logic [31:0] seed = 32'ha2ab8ad4, cmp;
    wave_pin_type pa, pb;
    flag_set_type svc = '0;
    int n_fail = 0, checked = 0;
    logic [1:0] acts [5] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE, ACT_TOGGLE};
    timer8_compare_normal_ctc timer8_compare_normal_ctc_i (.aclk(aclk), .aresetn(aresetn),
        .clk_en(1'b1), .timer_tick(tick), .flag_service(svc), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .wave_pin_a(pa), .wave_pin_b(pb));
    pin_model pin_model_i (.pin(pa), .line(line_a));
    pin_model pin_model_b_i (.pin(pb), .line(line_b));
    initial forever #10 aclk = ~aclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected output state after a match or force
    function automatic logic act_next(logic s, logic [1:0] a);
        return a == ACT_TOGGLE ? !s : a == ACT_CLEAR ? 1'b0 : a == ACT_SET ? 1'b1 : s;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s", $time, m);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                done = 1;
                bs = bresp;
            end
        end
        bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        bit done = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                done = 1;
                rd = rdata;
                rs = rresp;
            end
        end
        rready <= 0;
        @(posedge aclk);
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(OFS_STATUS);
        chk(rd, 0, "output state after reset");
        rdr(8'h20);
        chk(rs, RESP_SLVERR, "unmapped read");
        wr(8'h20, 32'h1);
        chk(bs, RESP_SLVERR, "unmapped write");
        st = 0;
        foreach (acts[i]) begin
            wr(OFS_CTRL, 32'(acts[i]) << CTRL_ACT_A_LSB);
            wr(OFS_FORCE, 1);
            st[0] = act_next(st[0], acts[i]);
            rdr(OFS_STATUS);
            chk(rd[0], st[0], "forced state");
        end
        wr(OFS_CTRL, 32'(ACT_SET) << CTRL_ACT_B_LSB);
        wr(OFS_FORCE, 2);
        wr(OFS_PIN, 2);
        repeat (2) @(posedge aclk);
        chk(line_b, 1, "forced set on pin b");
        rdr(OFS_FLAGS);
        chk(rd, 0, "force sets no flag");
        wr(OFS_CTRL, 32'(ACT_SET) << CTRL_ACT_A_LSB);
        wr(OFS_FORCE, 1);
        wr(OFS_PIN, 1);
        repeat (2) @(posedge aclk);
        chk(line_a, 1, "wave on pin");
        wr(OFS_PIN, 0);
        repeat (2) @(posedge aclk);
        chk(line_a, 0, "pin not output");
        wr(OFS_CTRL, 32'(MODE_CLEAR_ON_MATCH));
        wr(OFS_PIN, 1);
        repeat (2) @(posedge aclk);
        chk(line_a, 0, "port value on pin");
        rdr(OFS_STATUS);
        chk(rd[0], 1, "state kept over mode change");
        wr(OFS_CTRL, 0);
        wr(OFS_COMPARE_A, 8'hfc);
        wr(OFS_COUNT, 8'hfc);
        chk(bs, RESP_OKAY, "count write response");
        rdr(OFS_COUNT);
        chk(rd, 8'hfc, "stopped count");
        wr(OFS_CTRL, 32'h1 << CTRL_CS_LSB);
        repeat (10) @(posedge aclk);
        rdr(OFS_FLAGS);
        chk(rd[1:0], 2'b01, "overflow set, match blocked");
        svc.overflow <= 1'b1;
        @(posedge aclk);
        svc.overflow <= 1'b0;
        rdr(OFS_FLAGS);
        chk(rd[0], 0, "serviced overflow clear");
        wr(OFS_FLAGS, 7);
        rdr(OFS_FLAGS);
        chk(rd[2:0], 0, "flag write clear");
        cmp = 2 + rnd() % 8;
        wr(OFS_COMPARE_A, cmp);
        wr(OFS_CTRL, 32'h100 | 32'(ACT_TOGGLE) << CTRL_ACT_A_LSB | 32'(MODE_CLEAR_ON_MATCH));
        repeat (600) @(posedge aclk);
        rdr(OFS_FLAGS);
        chk(rd[1], 1, "match flag in clear mode");
        chk(rd[0], 1, "overflow on wrap in clear mode");
        rdr(OFS_COUNT);
        chk(rd <= cmp, 1, "count capped by compare");
        @(negedge aclk);
        st[0] = line_a;
        repeat (cmp + 1) @(negedge aclk);
        chk(line_a, !st[0], "toggle once per period");
        print_verdict();
    end
endmodule // test_timer8_compare_normal_ctc
`default_nettype wire
